/* File: src/pcst_pkg.sv */
/*
 Package for the power control slot timer: chip counts, positions and carriers.
 Assumes a chip strobe from the receiver, aligned to the received downlink frame.
*/
package pcst_pkg;
  localparam int unsigned SLOT_CHIPS = 2560;
  localparam int unsigned SLOTS_PER_FRAME = 15;
  localparam int unsigned UL_FRAME_OFFSET_CHIPS = 1024;
  localparam int unsigned TPC_AFTER_PILOT_CHIPS = 512;
  localparam logic [11:0] SLOT_LAST = 12'h9ff;
  localparam logic [3:0] FRAME_LAST_SLOT = 4'he;
  localparam logic [11:0] UL_OFFSET = 12'h400;
  localparam logic [11:0] TPC_GAP = 12'h200;
  localparam logic [11:0] CHIP_ZERO = 12'h000;
  localparam logic [3:0] SLOT_ZERO = 4'h0;
  localparam logic [11:0] DL_PILOT_END_DEFAULT = 12'h9ff;
  localparam logic [11:0] UL_PILOT_START_DEFAULT = 12'h000;
  localparam logic [7:0] SIR_ZERO = 8'h00;
  localparam logic [11:0] CHIP_STEP = 12'h001;
  localparam logic [3:0] SLOT_STEP = 4'h1;
  localparam logic [11:0] UL_EDGE_CHIP = 12'h3ff;
  localparam logic [11:0] UL_CHIP_AT_FRAME = 12'h600;
  localparam logic [11:0] TPC_COUNT_LAST = 12'h1fe;

  typedef struct packed {
    logic chip_stb;
    logic dl_frame_start;
    logic dl_tpc_valid;
    logic dl_tpc_up;
    logic sir_valid;
    logic [7:0] signal_to_interference_ratio;
    logic [7:0] sir_target;
  } pcst_in_t;

  typedef struct packed {
    logic ul_frame_start;
    logic ul_pilot_start;
    logic ul_tpc_field_start;
    logic ul_tpc_up;
    logic power_step;
    logic power_step_up;
  } pcst_out_t;
endpackage

/* File: src/pcst_timer.sv */
/*
 Power control slot timer for the terminal end of a dedicated channel.
 Assumes all inputs are synchronous to SYS_CLK_I and that IN_I.chip_stb pulses once per chip.
*/
`timescale 1ns/100ps
module pcst_timer (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire pcst_pkg::pcst_in_t IN_I,
  input wire logic [11:0] DL_PILOT_END_I,
  input wire logic [11:0] UL_PILOT_START_I,
  output pcst_pkg::pcst_out_t OUT_O,
  output logic [11:0] CHIP_O,
  output logic [3:0] SLOT_O
);
  import pcst_pkg::*;

  // Timing overview, in chips of the received downlink slot:
  //   Chip 0 of slot 0 is set by the frame start strobe.
  //   Uplink slot boundary sits at downlink chip 1024, uplink chip 0.
  //   Uplink frame start is that boundary in downlink slot 0.
  //   Uplink pilot start is a programmable uplink chip index.
  //   Command field start is 512 chips past the last downlink pilot chip.
  // Counters move on chip strobes only, so a slow strobe stretches
  // every position in clock cycles but not in chips.
  // Outputs are registered: every pulse shows one clock after the
  // strobe that reaches its position, together with the new chip index.
  // Hazards handled here:
  //   Command and pilot in one cycle: the command waits one slot.
  //   A second command before the pilot: the newer one replaces it.
  //   Frame start during a running field count: the count is dropped,
  //   since positions before and after the realignment do not match.
  //   Strobe in a frame start cycle: ignored, the frame start wins.
  // Limitation: pilot positions are levels; changing one while running
  //   can skip or repeat a pilot start in that slot.
  // Limitation: the uplink counter is only valid after a frame start;
  //   before the first one no strobe is expected.
  // Trade-off: the field count runs in chips from the pilot end
  //   instead of comparing chip indices, so a wrap needs no modulo.

  typedef struct packed {
    // Downlink position
    logic [11:0] chip;
    logic [3:0] slot;

    // Uplink position
    logic [11:0] ul_chip;

    // Command field count
    logic [11:0] tpc_cnt;
    logic tpc_armed;

    // Pending received command and own decision
    logic pend;
    logic pend_up;
    logic ul_tpc_up;

    // Registered outputs
    pcst_out_t out;
  } pcst_state_t;

  pcst_state_t st;
  pcst_state_t next_st;

  // Qualified events of this cycle
  logic frame_restart;
  logic chip_tick;
  logic dl_slot_end;
  logic dl_frame_end;
  logic ul_slot_edge;
  logic ul_slot_end;
  logic ul_pilot_hit;
  logic pilot_end_hit;
  logic tpc_due;
  logic step_now;
  logic sir_low;

  // Incremented copies of the counters, and the next uplink chip
  logic [11:0] chip_inc;
  logic [3:0] slot_inc;
  logic [11:0] ul_chip_inc;
  logic [11:0] tpc_cnt_inc;
  logic [11:0] ul_chip_next;

  // A strobe in a frame start cycle is dropped: realignment wins
  assign frame_restart = IN_I.dl_frame_start;
  assign chip_tick = IN_I.chip_stb && !IN_I.dl_frame_start;

  // Downlink slot and frame boundaries
  assign dl_slot_end = (st.chip == SLOT_LAST);
  assign dl_frame_end = (st.slot == FRAME_LAST_SLOT);
  assign chip_inc = st.chip + CHIP_STEP;
  assign slot_inc = st.slot + SLOT_STEP;

  // Uplink slot phase trails the downlink one by the fixed offset
  assign ul_slot_edge = (st.chip == UL_EDGE_CHIP);
  assign ul_slot_end = (st.ul_chip == SLOT_LAST);
  assign ul_chip_inc = st.ul_chip + CHIP_STEP;

  // Downlink chip 0 lies this far into the uplink slot, so pilot
  // positions are right from the first strobe after a frame start
  assign ul_chip_next = frame_restart ? UL_CHIP_AT_FRAME :
    !chip_tick ? st.ul_chip :
    (ul_slot_edge || ul_slot_end) ? CHIP_ZERO :
    ul_chip_inc;

  // Only a chip strobe can reach a new pilot position
  assign ul_pilot_hit = chip_tick && (ul_chip_next == UL_PILOT_START_I);

  // Pilot end arms the field count
  assign pilot_end_hit = chip_tick && (st.chip == DL_PILOT_END_I);
  assign tpc_cnt_inc = st.tpc_cnt + CHIP_STEP;
  assign tpc_due = chip_tick && !pilot_end_hit && st.tpc_armed &&
    (st.tpc_cnt == TPC_COUNT_LAST);

  // Only a command already pending before this cycle is applied
  assign step_now = ul_pilot_hit && st.pend;

  // Any estimator interval is fine; only the latest estimate counts
  assign sir_low = (IN_I.signal_to_interference_ratio < IN_I.sir_target);

  always_comb begin
    next_st = st;

    // Pulses last one cycle
    next_st.out.ul_frame_start = 1'b0;
    next_st.out.ul_pilot_start = 1'b0;
    next_st.out.ul_tpc_field_start = 1'b0;
    next_st.out.power_step = 1'b0;

    // Power decision from the measured ratio
    if (IN_I.sir_valid) begin
      next_st.ul_tpc_up = sir_low;
    end

    // Received command waits for the uplink pilot; newest command wins
    if (IN_I.dl_tpc_valid) begin
      next_st.pend = 1'b1;
      next_st.pend_up = IN_I.dl_tpc_up;
    end

    // Downlink chip and slot counters
    if (frame_restart) begin
      next_st.chip = CHIP_ZERO;
      next_st.slot = SLOT_ZERO;
    end else if (chip_tick) begin
      if (dl_slot_end) begin
        next_st.chip = CHIP_ZERO;
        if (dl_frame_end) begin
          next_st.slot = SLOT_ZERO;
        end else begin
          next_st.slot = slot_inc;
        end
      end else begin
        next_st.chip = chip_inc;
      end
    end

    // Uplink chip counter and frame start
    next_st.ul_chip = ul_chip_next;
    if (chip_tick && ul_slot_edge && (st.slot == SLOT_ZERO)) begin
      next_st.out.ul_frame_start = 1'b1;
    end

    // Uplink pilot start and the power change it carries
    if (ul_pilot_hit) begin
      next_st.out.ul_pilot_start = 1'b1;
    end
    if (step_now) begin
      next_st.out.power_step = 1'b1;
      next_st.out.power_step_up = st.pend_up;
      // A command arriving in this same cycle stays for the next pilot
      next_st.pend = IN_I.dl_tpc_valid;
    end

    // Uplink command field
    if (frame_restart) begin
      // A realigned frame invalidates a running field count
      next_st.tpc_armed = 1'b0;
      next_st.tpc_cnt = CHIP_ZERO;
    end else if (pilot_end_hit) begin
      next_st.tpc_armed = 1'b1;
      next_st.tpc_cnt = CHIP_ZERO;
    end else if (chip_tick && st.tpc_armed) begin
      next_st.tpc_cnt = tpc_cnt_inc;
    end
    if (tpc_due) begin
      next_st.tpc_armed = 1'b0;
      next_st.out.ul_tpc_field_start = 1'b1;
      next_st.out.ul_tpc_up = st.ul_tpc_up;
    end
  end

  // Asynchronous assert; release is expected synchronous upstream
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // All outputs straight from the state register
  assign OUT_O = st.out;
  assign CHIP_O = st.chip;
  assign SLOT_O = st.slot;
endmodule

/* File: verif/pcst_timer_monitor.sv */
/* Timer checker; one clock domain. */
`timescale 1ns/100ps
module pcst_timer_monitor import pcst_pkg::*; (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic [11:0] DL_PILOT_END_I,
  input wire logic [11:0] UL_PILOT_START_I,
  input wire logic [11:0] CHIP_O,
  input wire logic [3:0] SLOT_O,
  input wire pcst_out_t OUT_O);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_f; OUT_O.ul_frame_start |-> CHIP_O == UL_OFFSET && SLOT_O == SLOT_ZERO; endproperty
  a_f: assert property (p_f) else $error("frame");
  property p_t; OUT_O.ul_tpc_field_start |-> CHIP_O == (DL_PILOT_END_I + 512) % 2560; endproperty
  a_t: assert property (p_t) else $error("field");
  property p_s; OUT_O.power_step |-> OUT_O.ul_pilot_start; endproperty
  a_s: assert property (p_s) else $error("step");
  property p_p;
    OUT_O.ul_pilot_start |-> CHIP_O == (UL_PILOT_START_I + UL_FRAME_OFFSET_CHIPS) % SLOT_CHIPS;
  endproperty
  a_p: assert property (p_p) else $error("pilot");
  property p_r; CHIP_O <= SLOT_LAST && SLOT_O <= FRAME_LAST_SLOT; endproperty
  a_r: assert property (p_r) else $error("range");
  property p_c; $changed(CHIP_O) |-> CHIP_O == CHIP_ZERO || CHIP_O == $past(CHIP_O) + 12'h001;
  endproperty
  a_c: assert property (p_c) else $error("chip step");
  c_f: cover property (OUT_O.ul_frame_start);
  c_t: cover property (OUT_O.ul_tpc_field_start);
  c_s: cover property (OUT_O.power_step);
endmodule
bind pcst_timer pcst_timer_monitor u_mon (.*);

/* File: verif/pcst_bs_model.sv */
/* Base station model; drives 1 ns after each rising edge. */
`timescale 1ns/100ps
module pcst_bs_model import pcst_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic up_i,
  input wire logic tpc_i,
  input wire logic [11:0] chip_i,
  output pcst_in_t in_o = '0);
  localparam logic [11:0] LATE_CHIP = 12'h9c0;
  int n = 0;
  logic heard = 0, hold = 0, apply = 0;
  logic [11:0] last = 12'h000;
  always @(posedge clk_i) begin
    #1 n = rstn_i ? n + 1 : 0;
    apply = 0;
    // Step at the next slot start, or one slot later for a command heard past LATE_CHIP, taken as the downlink pilot start
    if (chip_i == CHIP_ZERO && last != CHIP_ZERO) begin
      apply = heard && !hold;
      heard = heard && hold;
      hold = 0;
    end
    if (tpc_i) begin
      heard = 1;
      hold = chip_i > LATE_CHIP;
    end
    if (!rstn_i) {heard, hold, apply} = 3'b000;
    last = chip_i;
    // Second frame start lands mid-slot on purpose; new command after each step
    in_o = '{n > 0 && $urandom % 4 > 0, n == 1 || n == 3000,
      n > 0 && (apply || $urandom % 60 == 0),
      !up_i, n % 500 == 7, 8'($urandom), 8'h80};
  end
endmodule

/* File: verif/tb_power_control_slot_timing.sv */
/* Slot timer bench; model drives inputs. */
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t bad value", $time); end end
module tb_power_control_slot_timing;
  import pcst_pkg::*;
  logic clk = 0, rst_n = 0, tk = 0, arm = 0, pend = 0, pend_up = 0, up = 0;
  logic fs_exp = 0, pil_exp = 0, tpc_exp = 0, step_exp = 0, step_up_exp = 0, tpc_up_exp = 0;
  logic [11:0] dl = SLOT_LAST, ul = CHIP_ZERO, cnt = CHIP_ZERO, old = CHIP_ZERO, chip;
  logic [3:0] scnt = SLOT_ZERO, slot;
  int mismatches = 0, samples_checked = 0;
  pcst_in_t i;
  pcst_out_t o;
  function automatic logic [11:0] chip_after(input logic [11:0] c, input int unsigned gap);
    return 12'((c + gap) % SLOT_CHIPS);
  endfunction
  pcst_bs_model u_bs (.clk_i(clk), .rstn_i(rst_n), .up_i(o.ul_tpc_up),
    .tpc_i(o.ul_tpc_field_start), .chip_i(chip), .in_o(i));
  pcst_timer u_dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .IN_I(i), .DL_PILOT_END_I(dl),
    .UL_PILOT_START_I(ul), .OUT_O(o), .CHIP_O(chip), .SLOT_O(slot));
  task automatic tally_and_finish();
    $display("checked %0d failed %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reference model at the edge; the design's answer is compared half a cycle later
  always @(posedge clk) begin
    tk = rst_n && i.chip_stb && !i.dl_frame_start;
    old = cnt;
    tpc_up_exp = up;
    step_up_exp = pend_up;
    if (!rst_n || i.dl_frame_start) begin
      cnt = CHIP_ZERO;
      scnt = SLOT_ZERO;
      arm = 0;
    end else if (tk) begin
      cnt = old == SLOT_LAST ? CHIP_ZERO : old + 12'h001;
      if (old == SLOT_LAST) scnt = scnt == FRAME_LAST_SLOT ? SLOT_ZERO : scnt + 4'h1;
    end
    fs_exp = tk && cnt == UL_OFFSET && scnt == SLOT_ZERO;
    pil_exp = tk && cnt == chip_after(ul, UL_FRAME_OFFSET_CHIPS);
    tpc_exp = tk && arm && cnt == chip_after(dl, TPC_AFTER_PILOT_CHIPS);
    if (tpc_exp) arm = 0;
    if (tk && old == dl) arm = 1;
    step_exp = pil_exp && pend;
    if (!rst_n) {pend, pend_up, up} = 3'b000;
    else begin
      if (step_exp) pend = i.dl_tpc_valid;
      else if (i.dl_tpc_valid) pend = 1;
      if (i.dl_tpc_valid) pend_up = i.dl_tpc_up;
      if (i.sir_valid) up = i.signal_to_interference_ratio < i.sir_target;
    end
  end
  always @(negedge clk) begin
    if (rst_n) begin
      `CHK(chip, cnt)
      `CHK(slot, scnt)
      `CHK(o.ul_frame_start, fs_exp)
      `CHK(o.ul_pilot_start, pil_exp)
      `CHK(o.power_step, step_exp)
      `CHK(o.ul_tpc_field_start, tpc_exp)
      if (step_exp) `CHK(o.power_step_up, step_up_exp)
      if (tpc_exp) `CHK(o.ul_tpc_up, tpc_up_exp)
    end
  end
  initial forever #12.5 clk = !clk;
  initial begin
    void'($urandom(59));
    repeat (2) begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1;
      repeat (12000) @(posedge clk);
      #1 rst_n = 0;
      dl = 12'($urandom_range(2559));
      ul = 12'($urandom_range(2559));
    end
    tally_and_finish();
  end
endmodule
